// ---- low_power_clock_gating_unit.sv ----
// power mode and peripheral clock gating unit
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_defs.svh"
module low_power_clock_gating_unit (
  // clock and synchronous reset
  input  wire logic              MCLK,
  input  wire logic              RESET,
  // special-function bus
  input  wire lpcg_pkg::sfr_req_t SFR_REQ,
  output logic      [7:0]         SFR_RDATA,
  // core status and reset sources
  input  wire logic              CPU_IDLE,
  input  wire logic              RESET_SRC,
  // pins: reset pin and wake events
  input  wire logic              RST_PIN_N,
  input  wire logic [5:0]        WAKE_EVENT,
  // clock controls
  output logic      [3:0]        PERIPH_CLK_EN,
  output logic                   CPU_CLK_EN,
  output logic                   SYS_CLK_EN,
  output logic                   OSC_EN,
  output logic                   LP_OSC_EN,
  // supply and pin controls
  output logic                   CORE_REG_EN,
  output logic                   RAM_ON_BAT,
  output logic                   PIN_HOLD,
  output logic                   PORT_MATCH_ARMED,
  output logic                   WAKE_REQ_N,
  output logic                   FULL_POR_REQ,
  output logic                   SUPPLY_MON_DIS
);
  lpcg_pkg::state_t q;        // registered state
  lpcg_pkg::state_t nx;       // next state
  logic [6:0]       pin_s;    // synchronised pins
  logic [5:0]       evt_s;    // synchronised events
  logic             rst_s;    // synchronised reset pin
  logic [5:0]       evt_rise; // event edges this cycle
  logic             rst_fall; // reset pin falling edge
  logic [6:0]       flag_set; // per-flag set pulses
  logic [6:0]       flags;    // sticky wake flags
  logic             clr_all;  // software clear of flags
  logic             cfg_wr;   // write to wake configuration
  logic             flg_wr;   // write to flag register
  logic             wake;     // a wake condition is present
  logic             enter_ok; // entry allowed
  logic             lp_idle;  // gated idle operation
  logic             lp_act;   // gated active operation

  // pins cross into the system clock domain first
  pin_sync #(.W(7)) u_sync (
    .clk   (MCLK),
    .reset (RESET),
    .din   ({RST_PIN_N, WAKE_EVENT}),
    .dout  (pin_s)
  );

  assign evt_s    = pin_s[5:0];
  assign rst_s    = pin_s[6];
  assign evt_rise = evt_s & ~q.evt_prev;
  assign rst_fall = q.rst_prev & ~rst_s;  // any glitch edge counts
  assign cfg_wr   = SFR_REQ.wr && (SFR_REQ.addr == `WAKE_CFG_ADDR);
  assign flg_wr   = SFR_REQ.wr && (SFR_REQ.addr == `WAKE_FLAG_ADDR);
  assign clr_all  = cfg_wr && SFR_REQ.wdata[`CFG_CLEAR_BIT];
  // flag order: comparator, port match, alarm, osc fail, pin, pulse, battery
  assign flag_set = {evt_rise[5], evt_rise[4], rst_fall, evt_rise[3:0]};

  // one sticky flag per wake source, updated in every mode
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_flag
      wake_flag_cell u_flag (
        .clk   (MCLK),
        .reset (RESET),
        .set   (flag_set[gi]),
        .clr   (clr_all),
        .flag  (flags[gi])
      );
    end
  endgenerate

  // enabled events or the reset pin end a low-power mode
  assign wake     = (|(evt_rise & q.wake_en)) || rst_fall;
  // a pending flag blocks entry unless the same write clears it
  assign enter_ok = !((|flags) && !clr_all);
  assign lp_idle  = q.lpm_en && CPU_IDLE;
  assign lp_act   = q.lpm_en && !CPU_IDLE;

  // next-state logic: registers, mode machine, outputs
  always_comb
  begin
    nx          = q;
    nx.evt_prev = evt_s;
    nx.rst_prev = rst_s;
    nx.full_por = 1'b0;
    if (q.mask_cnt != 2'h0)
      nx.mask_cnt = q.mask_cnt - 2'h1;
    // register writes; unused upper bits are dropped
    if (SFR_REQ.wr)
    begin
      case (SFR_REQ.addr)
        `ACT_OVR_ADDR:  nx.override = SFR_REQ.wdata[3:0];
        `IDLE_EN_ADDR:  nx.idle_en  = SFR_REQ.wdata[3:0];
        `CLK_MODE_ADDR: nx.lpm_en   = SFR_REQ.wdata[`GATE_EN_BIT];
        `WAKE_CFG_ADDR: nx.wake_en[3:0] = SFR_REQ.wdata[3:0];
        `WAKE_FLAG_ADDR:
        begin
          nx.wake_en[4] = SFR_REQ.wdata[`FLG_PC_BIT];
          nx.wake_en[5] = SFR_REQ.wdata[`FLG_BAT_BIT];
        end
        `PWR_MODE_ADDR: nx.mon_dis = SFR_REQ.wdata[`MON_DIS_BIT];
        default:        nx.mon_dis = q.mon_dis;
      endcase
    end
    // with the monitor off, any reset becomes a full power-on reset
    if (q.mon_dis && (rst_fall || RESET_SRC))
    begin
      nx.full_por = 1'b1;
      nx.mon_dis  = 1'b0;
    end
    // mode machine; state registers are never touched by sleep
    case (q.mode)
      lpcg_pkg::MODE_NORMAL:
      begin
        if (cfg_wr && enter_ok && SFR_REQ.wdata[`CFG_SLEEP_BIT])
        begin
          nx.mode       = lpcg_pkg::MODE_SLEEP;
          nx.wake_req_n = 1'b1;
        end
        else if (cfg_wr && enter_ok && SFR_REQ.wdata[`CFG_SUSPEND_BIT])
          nx.mode = lpcg_pkg::MODE_SUSPEND;
      end
      lpcg_pkg::MODE_SUSPEND:
      begin
        if (wake)
        begin
          nx.mode     = lpcg_pkg::MODE_NORMAL;
          nx.mask_cnt = `WAKE_MASK_CYCLES;
        end
      end
      lpcg_pkg::MODE_SLEEP:
      begin
        if (wake)
        begin
          nx.mode       = lpcg_pkg::MODE_NORMAL;
          nx.wake_req_n = 1'b0;
        end
      end
      default: nx.mode = lpcg_pkg::MODE_NORMAL;
    endcase
    // read data; unused and reserved bits read zero
    nx.rdata = 8'h00;
    if (SFR_REQ.rd)
    begin
      case (SFR_REQ.addr)
        `ACT_OVR_ADDR:  nx.rdata = {4'h0, q.override};
        `IDLE_EN_ADDR:  nx.rdata = {4'h0, q.idle_en};
        `CLK_MODE_ADDR: nx.rdata = {5'h00, q.lpm_en, 2'h0};
        `WAKE_CFG_ADDR:
          if (q.mask_cnt == 2'h0)
            nx.rdata = {3'h0, flags[4:0]};
        `WAKE_FLAG_ADDR:
          if (q.mask_cnt == 2'h0)
            nx.rdata = {5'h00, flags[6], 1'b0, flags[5]};
        `PWR_MODE_ADDR: nx.rdata = {2'h0, q.mon_dis, 5'h00};
        default:        nx.rdata = 8'h00;
      endcase
    end
    // clock tree gates from the present mode
    nx.periph_en  = 4'h0;
    nx.cpu_clk_en = 1'b0;
    if (q.mode == lpcg_pkg::MODE_NORMAL)
    begin
      // bit3 rtc/pulse/power unit, bit2 timers/crc, bit1 adc/pca, bit0 serial
      if (lp_idle)
        nx.periph_en = q.idle_en;
      else if (lp_act)
        nx.periph_en = q.idle_en | q.override;
      else
        nx.periph_en = 4'hf;
      nx.cpu_clk_en = !lp_idle;
    end
    nx.sys_clk_en  = (q.mode == lpcg_pkg::MODE_NORMAL);
    nx.osc_en      = (q.mode == lpcg_pkg::MODE_NORMAL);
    // the low-power oscillator cannot stop while a flag is pending
    nx.lposc_en    = (q.mode == lpcg_pkg::MODE_NORMAL) || (|flags);
    nx.core_reg_en = (q.mode != lpcg_pkg::MODE_SLEEP);
    nx.ram_on_bat  = (q.mode == lpcg_pkg::MODE_SLEEP);
    nx.pin_hold    = (q.mode == lpcg_pkg::MODE_SLEEP);
    nx.pm_armed    = (q.mode == lpcg_pkg::MODE_SLEEP);
  end

  // state register
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      q             <= '0;
      q.mode        <= lpcg_pkg::MODE_NORMAL;
      q.override    <= `ACT_OVR_RESET;
      q.idle_en     <= `IDLE_EN_RESET;
      q.rst_prev    <= 1'b1;
      q.periph_en   <= 4'hf;
      q.cpu_clk_en  <= 1'b1;
      q.sys_clk_en  <= 1'b1;
      q.osc_en      <= 1'b1;
      q.lposc_en    <= 1'b1;
      q.core_reg_en <= 1'b1;
      q.wake_req_n  <= 1'b1;
    end
    else
      q <= nx;
  end

  // ports straight from the state flops
  assign SFR_RDATA        = q.rdata;
  assign PERIPH_CLK_EN    = q.periph_en;
  assign CPU_CLK_EN       = q.cpu_clk_en;
  assign SYS_CLK_EN       = q.sys_clk_en;
  assign OSC_EN           = q.osc_en;
  assign LP_OSC_EN        = q.lposc_en;
  assign CORE_REG_EN      = q.core_reg_en;
  assign RAM_ON_BAT       = q.ram_on_bat;
  assign PIN_HOLD         = q.pin_hold;
  assign PORT_MATCH_ARMED = q.pm_armed;
  assign WAKE_REQ_N       = q.wake_req_n;
  assign FULL_POR_REQ     = q.full_por;
  assign SUPPLY_MON_DIS   = q.mon_dis;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  // named steps of the wake sequences
  sequence s_suspend_wake;
    (q.mode == lpcg_pkg::MODE_SUSPEND) ##1 (q.mode == lpcg_pkg::MODE_NORMAL);
  endsequence
  sequence s_sleep_wake;
    (q.mode == lpcg_pkg::MODE_SLEEP) ##1 (q.mode == lpcg_pkg::MODE_NORMAL);
  endsequence

  idle_gating_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && q.lpm_en && CPU_IDLE)
    |=> (PERIPH_CLK_EN == $past(q.idle_en)) && !CPU_CLK_EN)
    else $error("idle gating does not follow idle enables");
  active_override_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && q.lpm_en && !CPU_IDLE)
    |=> PERIPH_CLK_EN == ($past(q.idle_en) | $past(q.override)))
    else $error("active override not applied");
  gating_enable_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && !q.lpm_en) |=> PERIPH_CLK_EN == 4'hf && CPU_CLK_EN)
    else $error("gating without gating enable");
  suspend_clock_a : assert property (
    (q.mode == lpcg_pkg::MODE_SUSPEND) |=> !SYS_CLK_EN && !OSC_EN)
    else $error("clock running in suspend");
  sleep_power_a : assert property (
    (q.mode == lpcg_pkg::MODE_SLEEP) |=> !CORE_REG_EN && RAM_ON_BAT && PIN_HOLD)
    else $error("sleep supply state wrong");
  flag_mask_a : assert property (
    s_suspend_wake |-> (q.mask_cnt == 2'h2) ##1 (q.mask_cnt == 2'h1) ##1 (q.mask_cnt == 2'h0))
    else $error("flag mask window not two clocks");
  pin_wake_a : assert property (
    (q.mode != lpcg_pkg::MODE_NORMAL && rst_fall) |=> q.mode == lpcg_pkg::MODE_NORMAL)
    else $error("reset pin edge did not wake");
  refuse_entry_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && cfg_wr && (|flags) && !clr_all)
    |=> q.mode == lpcg_pkg::MODE_NORMAL)
    else $error("entered low power with flag set");
  wake_request_a : assert property (
    s_sleep_wake |-> !WAKE_REQ_N)
    else $error("wake request not low after sleep");
  full_por_a : assert property (
    (q.mon_dis && (rst_fall || RESET_SRC)) |=> FULL_POR_REQ && !SUPPLY_MON_DIS)
    else $error("no full power-on reset with monitor off");
  unused_bits_a : assert property (
    (SFR_REQ.rd && (SFR_REQ.addr == `IDLE_EN_ADDR || SFR_REQ.addr == `ACT_OVR_ADDR))
    |=> SFR_RDATA[7:4] == 4'h0)
    else $error("unused gating bits read nonzero");

  // a pending flag keeps the low-power oscillator running
  lposc_flag_a : assert property (
    (|flags) |=> LP_OSC_EN)
    else $error("low-power oscillator stopped with flag set");

  // flag registers read zero while the mask counter runs
  mask_read_a : assert property (
    (q.mask_cnt != 2'h0 && SFR_REQ.rd
     && (SFR_REQ.addr == `WAKE_CFG_ADDR || SFR_REQ.addr == `WAKE_FLAG_ADDR))
    |=> SFR_RDATA == 8'h00)
    else $error("wake flags visible inside mask window");

  // reserved clock mode bits always read zero
  reserved_read_a : assert property (
    (SFR_REQ.rd && SFR_REQ.addr == `CLK_MODE_ADDR)
    |=> SFR_RDATA[7:3] == 5'h00 && SFR_RDATA[1:0] == 2'h0)
    else $error("reserved clock mode bits read nonzero");

  // inputs stay armed for port match through sleep
  match_armed_a : assert property (
    (q.mode == lpcg_pkg::MODE_SLEEP) |=> PORT_MATCH_ARMED)
    else $error("port match not armed in sleep");

  // in normal mode the core clock only stops in gated idle
  active_cpu_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && !CPU_IDLE) |=> CPU_CLK_EN)
    else $error("core clock stopped while active");

  // nothing downstream is clocked in suspend
  suspend_gate_a : assert property (
    (q.mode == lpcg_pkg::MODE_SUSPEND) |=> PERIPH_CLK_EN == 4'h0 && !CPU_CLK_EN)
    else $error("peripheral clock running in suspend");

  // an accepted suspend write enters suspend next cycle
  suspend_entry_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && cfg_wr && enter_ok
     && SFR_REQ.wdata[`CFG_SUSPEND_BIT] && !SFR_REQ.wdata[`CFG_SLEEP_BIT])
    |=> q.mode == lpcg_pkg::MODE_SUSPEND)
    else $error("suspend write did not enter suspend");

  // sleep wins over suspend when both are written
  sleep_entry_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL && cfg_wr && enter_ok && SFR_REQ.wdata[`CFG_SLEEP_BIT])
    |=> q.mode == lpcg_pkg::MODE_SLEEP)
    else $error("sleep write did not enter sleep");

  // sleep stops the system clock and the main oscillators too
  sleep_clock_a : assert property (
    (q.mode == lpcg_pkg::MODE_SLEEP) |=> !SYS_CLK_EN && !OSC_EN && !CPU_CLK_EN)
    else $error("clock running in sleep");

  // without an event or a pin edge the low-power mode holds
  event_only_a : assert property (
    (q.mode != lpcg_pkg::MODE_NORMAL && evt_rise == 6'h00 && !rst_fall)
    |=> q.mode == $past(q.mode))
    else $error("left low power without a wake event");

  // an enabled event ends suspend or sleep
  enabled_wake_a : assert property (
    (q.mode != lpcg_pkg::MODE_NORMAL && (|(evt_rise & q.wake_en)))
    |=> q.mode == lpcg_pkg::MODE_NORMAL)
    else $error("enabled event did not wake");

  // pulse and battery enables live in the flag register
  wake_enable_a : assert property (
    flg_wr |=> q.wake_en[5:4] == {$past(SFR_REQ.wdata[`FLG_BAT_BIT]),
                                  $past(SFR_REQ.wdata[`FLG_PC_BIT])})
    else $error("pulse or battery enable not stored");

  // a clear with no new event empties every flag
  flag_clear_a : assert property (
    (clr_all && flag_set == 7'h00) |=> flags == 7'h00)
    else $error("flag clear left a flag set");

  // gating settings survive sleep untouched
  sleep_retain_a : assert property (
    (q.mode == lpcg_pkg::MODE_SLEEP && !SFR_REQ.wr)
    |=> $stable(q.idle_en) && $stable(q.override) && $stable(q.lpm_en))
    else $error("gating settings lost in sleep");

  // the full power-on reset request lasts one cycle
  por_pulse_a : assert property (
    FULL_POR_REQ |=> !FULL_POR_REQ)
    else $error("full power-on reset request stuck");

  // normal mode runs the system clock, the oscillator and the core regulator
  normal_clock_a : assert property (
    (q.mode == lpcg_pkg::MODE_NORMAL) |=> SYS_CLK_EN && OSC_EN && CORE_REG_EN && !RAM_ON_BAT)
    else $error("normal mode supply or clock wrong");
endmodule
`default_nettype wire

// ---- lpcg_defs.svh ----
// constants of the low-power clock gating unit
// Functional notes
// - override bit forces group clock in active
// - idle enable bit gates group in idle
// - bit 3: rtc, pulse counter, power unit
// - bit 2 timers/crc; bit 1 converter/pca
// - bit 0: uart, timer 3, spi, smbus
// - gating bits 7:4 read zero, ignored
// - gating modes only while gating enable set
// - suspend gates system clock, stops oscillators
// - six enabled events wake suspend or sleep
// - flags read zero two clocks after suspend
// - reset pin falling edge always wakes
// - sleep: regulator off, ram on battery
// - digital outputs hold level in sleep
// - digital inputs stay port match sources
// - leaving sleep drives wake request low
// - all volatile state kept through sleep
// - monitor disabled: reset gives full por
// - flags record events whether enabled or not
// - no suspend or sleep while flag set
`ifndef LPCG_DEFS_SVH
`define LPCG_DEFS_SVH
`define ACT_OVR_ADDR     8'hf5
`define CLK_MODE_ADDR    8'hfd
`define IDLE_EN_ADDR     8'hfe
`define WAKE_CFG_ADDR    8'hb5
`define WAKE_FLAG_ADDR   8'hb6
`define PWR_MODE_ADDR    8'hb7
`define ACT_OVR_RESET    4'h0
`define IDLE_EN_RESET    4'h0
`define GATE_EN_BIT      2
`define CFG_SLEEP_BIT    7
`define CFG_SUSPEND_BIT  6
`define CFG_CLEAR_BIT    5
`define FLG_BAT_BIT      2
`define FLG_PC_BIT       0
`define MON_DIS_BIT      5
`define WAKE_MASK_CYCLES 2'h2
`endif

// ---- lpcg_pkg.sv ----
// types of the low-power clock gating unit
package lpcg_pkg;
  // power modes of the device
  typedef enum logic [1:0]
  {
    MODE_NORMAL  = 2'b00,
    MODE_SUSPEND = 2'b01,
    MODE_SLEEP   = 2'b10
  } pmode_t;
  // special-function bus request
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  // complete state of the top module
  typedef struct packed
  {
    pmode_t     mode;
    logic [3:0] override;
    logic [3:0] idle_en;
    logic       lpm_en;
    logic [5:0] wake_en;
    logic       mon_dis;
    logic [5:0] evt_prev;
    logic       rst_prev;
    logic [1:0] mask_cnt;
    logic [7:0] rdata;
    logic [3:0] periph_en;
    logic       cpu_clk_en;
    logic       sys_clk_en;
    logic       osc_en;
    logic       lposc_en;
    logic       core_reg_en;
    logic       ram_on_bat;
    logic       pin_hold;
    logic       pm_armed;
    logic       wake_req_n;
    logic       full_por;
  } state_t;
endpackage

// ---- pin_sync.sv ----
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [1:0][W-1:0] st_reg;  // stage 1 feeds only stage 0
  logic [1:0][W-1:0] st_next;

  // shift chain; no reset, so a pin's idle level flushes through while reset is held
  // and the edge detectors never see a false edge when reset lets go
  always_comb
  begin
    st_next[1] = din;
    st_next[0] = st_reg[1];
  end

  // register both stages; reset is deliberately left unused
  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  // only the second stage is read outside
  assign dout = st_reg[0];
endmodule
`default_nettype wire

// ---- wake_flag_cell.sv ----
// one sticky wake flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module wake_flag_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // event and clear
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  logic flag_reg;   // sticky flag
  logic flag_next;

  // event set beats a simultaneous clear
  always_comb
  begin
    flag_next = flag_reg;
    if (clr)
      flag_next = 1'b0;
    if (set)
      flag_next = 1'b1;
  end

  // register the flag
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag = flag_reg;

  flag_record_a : assert property (@(posedge clk) disable iff (reset) set |=> flag)
    else $error("wake flag missed its event");
endmodule
`default_nettype wire

// ---- low_power_clock_gating_unit_tb_top.sv ----
// self-checking testbench of the low-power clock gating unit
`timescale 1ns/1ps
`default_nettype none
module low_power_clock_gating_unit_tb_top;
  logic               mclk;        // system clock, 200 MHz
  logic               reset;       // synchronous, active high
  lpcg_pkg::sfr_req_t sfr_req;     // special-function bus request
  logic [7:0]         sfr_rdata;   // registered read data
  logic               cpu_idle;    // core idle level
  logic               reset_src;   // internal reset source
  logic               rst_pin_n;   // reset pin, active low
  logic [5:0]         wake_event;  // asynchronous event levels
  logic [3:0]         periph_clk_en;
  logic               cpu_clk_en;
  logic               sys_clk_en;
  logic               osc_en;
  logic               lp_osc_en;
  logic               core_reg_en;
  logic               ram_on_bat;
  logic               pin_hold;
  logic               port_match_armed;
  logic               wake_req_n;
  logic               full_por_req;
  logic               supply_mon_dis;
  int                 err_count;   // mismatches seen
  int                 comparisons; // checks made

  low_power_clock_gating_unit dut (
    .MCLK(mclk), .RESET(reset), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
    .CPU_IDLE(cpu_idle), .RESET_SRC(reset_src), .RST_PIN_N(rst_pin_n),
    .WAKE_EVENT(wake_event), .PERIPH_CLK_EN(periph_clk_en), .CPU_CLK_EN(cpu_clk_en),
    .SYS_CLK_EN(sys_clk_en), .OSC_EN(osc_en), .LP_OSC_EN(lp_osc_en),
    .CORE_REG_EN(core_reg_en), .RAM_ON_BAT(ram_on_bat), .PIN_HOLD(pin_hold),
    .PORT_MATCH_ARMED(port_match_armed), .WAKE_REQ_N(wake_req_n),
    .FULL_POR_REQ(full_por_req), .SUPPLY_MON_DIS(supply_mon_dis)
  );

  // free-running clock, 5 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // verdict and end of run, the single exit point
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one comparison; four-state so an unknown never matches
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // step to just after the next rising edge, where inputs change
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // single-byte write, taken at the next edge; one idle edge before the next request
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick();
    sfr_req = '0;
    tick();
  endtask

  // single-byte read, data valid the cycle after the request edge
  task automatic sfr_rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick();
    chk(name, exp, sfr_rdata);
    sfr_req = '0;
    tick();
  endtask

  // bounded wait on a design output; running out ends the run
  task automatic wait_until(input int sel);
    int n;
    n = 0;
    while (n < 20 && !(sel == 0 ? sys_clk_en === 1'b1 :
                       sel == 1 ? core_reg_en === 1'b1 : full_por_req === 1'b1))
    begin
      tick();
      n++;
    end
    if (n == 20)
    begin
      err_count++;
      $display("[ERR] wait_until %0d expected 1 seen timeout", sel);
      end_sim();
    end
  endtask

  // reset values, unused and reserved bits, unmapped address
  task automatic scen_regs();
    sfr_rd("override_rst", 8'hf5, 8'h00);
    sfr_rd("clk_mode_rst", 8'hfd, 8'h00);
    sfr_rd("idle_en_rst", 8'hfe, 8'h00);
    chk("periph_normal", 8'h0f, periph_clk_en);
    sfr_wr(8'hfe, 8'hff);
    sfr_rd("idle_en_hi", 8'hfe, 8'h0f);
    sfr_wr(8'hf5, 8'hf3);
    sfr_rd("override_hi", 8'hf5, 8'h03);
    sfr_wr(8'hfd, 8'h04);
    sfr_rd("clk_mode_rd", 8'hfd, 8'h04);
    sfr_rd("unmapped", 8'h42, 8'h00);
    sfr_wr(8'hfd, 8'h00);
  endtask

  // group gating in low-power idle and active, one bit at a time
  task automatic scen_gating();
    for (int i = 0; i < 4; i++)
    begin
      sfr_wr(8'hfe, 8'h01 << i);
      sfr_wr(8'hf5, 8'h01 << ((i + 1) % 4));
      sfr_wr(8'hfd, 8'h00);
      repeat (2) tick();
      chk("periph_no_lpm", 8'h0f, periph_clk_en);
      sfr_wr(8'hfd, 8'h04);
      cpu_idle = 1'b1;
      repeat (3) tick();
      chk("periph_idle", 8'h01 << i, periph_clk_en);
      chk("cpu_idle_gated", 8'h00, cpu_clk_en);
      cpu_idle = 1'b0;
      repeat (3) tick();
      chk("periph_act", (8'h01 << i) | (8'h01 << ((i + 1) % 4)), periph_clk_en);
      chk("cpu_active", 8'h01, cpu_clk_en);
    end
    sfr_wr(8'hfd, 8'h00);
  endtask

  // suspend entry and wake from each of the six sources
  task automatic scen_suspend();
    for (int i = 0; i < 6; i++)
    begin
      sfr_wr(8'hb5, 8'h20);
      sfr_wr(8'hb6, i == 4 ? 8'h01 : (i == 5 ? 8'h04 : 8'h00));
      // the bench clock already stands for the internal oscillator; re-entry is at once
      sfr_wr(8'hb5, 8'h40 | (i < 4 ? 8'h01 << i : 8'h00));
      repeat (2) tick();
      chk("sys_clk_susp", 8'h00, sys_clk_en);
      chk("osc_susp", 8'h00, osc_en);
      wake_event[i] = 1'b1;
      wait_until(0);
      sfr_rd("flags_masked", 8'hb5, 8'h00);
      repeat (3) tick();
      if (i < 4)
        sfr_rd("flag_cfg", 8'hb5, 8'h01 << i);
      else
        sfr_rd("flag_fl", 8'hb6, i == 4 ? 8'h01 : 8'h04);
      wake_event[i] = 1'b0;
      repeat (3) tick();
    end
  endtask

  // disabled event flags but does not wake; entry refused while flagged
  task automatic scen_flags();
    sfr_wr(8'hb5, 8'h20);
    sfr_wr(8'hb6, 8'h00);
    sfr_wr(8'hb5, 8'h41);
    repeat (2) tick();
    wake_event[1] = 1'b1;
    repeat (8) tick();
    chk("no_wake_dis", 8'h00, sys_clk_en);
    wake_event[0] = 1'b1;
    wait_until(0);
    repeat (3) tick();
    sfr_rd("flags_both", 8'hb5, 8'h03);
    wake_event = 6'h00;
    sfr_wr(8'hb5, 8'h41);
    repeat (3) tick();
    chk("refuse_sys", 8'h01, sys_clk_en);
    chk("refuse_lposc", 8'h01, lp_osc_en);
    sfr_wr(8'hb5, 8'h20);
  endtask

  // sleep entry, pin wake, wake request and retained state
  task automatic scen_sleep();
    sfr_wr(8'hfe, 8'h0a);
    // no analog enables reach this block, so none is left on here
    sfr_wr(8'hb5, 8'h80);
    repeat (2) tick();
    chk("core_reg_off", 8'h00, core_reg_en);
    chk("ram_bat", 8'h01, ram_on_bat);
    chk("pin_hold", 8'h01, pin_hold);
    chk("pm_armed", 8'h01, port_match_armed);
    chk("wake_req_hi", 8'h01, wake_req_n);
    rst_pin_n = 1'b0;
    repeat (2) tick();
    rst_pin_n = 1'b1;
    wait_until(1);
    tick();
    chk("wake_req_lo", 8'h00, wake_req_n);
    chk("ram_core", 8'h00, ram_on_bat);
    chk("pin_release", 8'h00, pin_hold);
    sfr_rd("pin_flag", 8'hb5, 8'h10);
    sfr_rd("idle_kept", 8'hfe, 8'h0a);
    // after a pin wake, stay awake 15 us before sleeping again
    repeat (3000) tick();
    sfr_wr(8'hb5, 8'ha0);
    repeat (2) tick();
    chk("wake_req_rearm", 8'h01, wake_req_n);
    rst_pin_n = 1'b0;
    repeat (2) tick();
    rst_pin_n = 1'b1;
    wait_until(1);
    sfr_wr(8'hb5, 8'h20);
  endtask

  // reset source gives full power-on reset only with monitor disabled
  task automatic scen_monitor();
    reset_src = 1'b1;
    tick();
    reset_src = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      chk("no_por", 8'h00, full_por_req);
      tick();
    end
    sfr_wr(8'hb7, 8'h20);
    tick();
    chk("mon_dis_set", 8'h01, supply_mon_dis);
    reset_src = 1'b1;
    tick();
    reset_src = 1'b0;
    wait_until(2);
    repeat (3) tick();
    chk("mon_dis_clr", 8'h00, supply_mon_dis);
    chk("por_pulse", 8'h00, full_por_req);
  endtask

  // main sequence
  initial
  begin
    err_count = 0;
    comparisons = 0;
    reset = 1'b1;
    sfr_req = '0;
    cpu_idle = 1'b0;
    reset_src = 1'b0;
    rst_pin_n = 1'b1;
    wake_event = 6'h00;
    repeat (16) tick();
    reset = 1'b0;
    scen_regs();
    scen_gating();
    scen_suspend();
    scen_flags();
    scen_sleep();
    scen_monitor();
    end_sim();
  end

  // overall limit against a hang
  initial
  begin
    #100000;
    err_count++;
    $display("[ERR] run_limit expected done seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
